// File: hdl/airq_router.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// interrupt enable and routing with an ahb-lite register slave
////////////////////////////////////////////////////////////////////////////////
module airq_router
#(
	parameter int ADDR_WIDTH = 8   // byte address width seen by the slave
)
(
	input wire logic i_clock,
	input wire logic i_rstn,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [ADDR_WIDTH-1:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// event flags from the source functions, level while active
	input wire airq_pkg::airq_sources_t i_event_flags,
	// primary interrupt pin
	input wire logic i_irq_line_primary_in,
	output logic o_irq_line_primary_out,
	output logic o_irq_line_primary_oe,
	// secondary interrupt pin
	input wire logic i_irq_line_secondary_in,
	output logic o_irq_line_secondary_out,
	output logic o_irq_line_secondary_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// functions

	// word index of a byte address; the low two bits select a byte lane only
	function automatic logic [5:0] word_index(input logic [ADDR_WIDTH-1:0] addr);
		word_index = addr[7:2];
	endfunction : word_index

	// keep only bits that have a source behind them
	function automatic airq_pkg::airq_sources_t source_bits(input logic [7:0] value);
		source_bits = airq_pkg::airq_sources_t'(value & airq_pkg::SOURCE_MASK);
	endfunction : source_bits

	////////////////////////////////////////////////////////////////////////////////
	// register state

	airq_pkg::airq_sources_t interrupt_enable;       // per-source enable
	airq_pkg::airq_sources_t interrupt_routing;      // per-source pin select
	airq_pkg::airq_pin_cfg_t pin_cfg;                // polarity and drive type
	airq_pkg::airq_sources_t next_interrupt_enable;
	airq_pkg::airq_sources_t next_interrupt_routing;
	airq_pkg::airq_pin_cfg_t next_pin_cfg;

	// bus data phase state
	logic write_pending;                             // a write is in its data phase
	logic [5:0] write_index;                         // its register index
	logic next_write_pending;
	logic [5:0] next_write_index;
	logic [31:0] next_hrdata;

	// sampled pin levels, shown in the status register
	logic primary_pin_level;
	logic secondary_pin_level;

	////////////////////////////////////////////////////////////////////////////////
	// event gating and routing

	airq_pkg::airq_sources_t gated_events;           // events whose enable is set
	logic primary_request;                           // some source wants the primary pin
	logic secondary_request;                         // some source wants the secondary pin
	airq_pkg::airq_pin_drive_t primary_drive;
	airq_pkg::airq_pin_drive_t secondary_drive;

	// gate each flag by its own enable, then split by routing bit
	always_comb
	begin
		gated_events = '0;
		gated_events.sleep_wake = i_event_flags.sleep_wake & interrupt_enable.sleep_wake;
		gated_events.fifo = i_event_flags.fifo & interrupt_enable.fifo;
		gated_events.transient = i_event_flags.transient & interrupt_enable.transient;
		gated_events.orientation = i_event_flags.orientation & interrupt_enable.orientation;
		gated_events.pulse = i_event_flags.pulse & interrupt_enable.pulse;
		gated_events.freefall_motion = i_event_flags.freefall_motion & interrupt_enable.freefall_motion;
		gated_events.data_ready = i_event_flags.data_ready & interrupt_enable.data_ready;
		primary_request = |(gated_events & interrupt_routing);
		secondary_request = |(gated_events & ~interrupt_routing);
	end

	// primary pin output stage
	airq_pin_driver primary_driver
	(
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_assert(primary_request),
		.i_cfg(pin_cfg),
		.o_drive(primary_drive)
	);

	// secondary pin output stage
	airq_pin_driver secondary_driver
	(
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_assert(secondary_request),
		.i_cfg(pin_cfg),
		.o_drive(secondary_drive)
	);

	// pin ports come straight from the driver flip-flops
	assign o_irq_line_primary_out = primary_drive.out;
	assign o_irq_line_primary_oe = primary_drive.oe;
	assign o_irq_line_secondary_out = secondary_drive.out;
	assign o_irq_line_secondary_oe = secondary_drive.oe;

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: address phase capture and register writes

	logic transfer_valid;                            // a real transfer is offered
	logic [5:0] addr_index;                          // index of the offered address

	// next values for the bus state and the writable registers
	always_comb
	begin
		transfer_valid = i_hsel & i_hready & (i_htrans == airq_pkg::HTRANS_NONSEQ || i_htrans == airq_pkg::HTRANS_SEQ);
		addr_index = word_index(i_haddr);
		next_interrupt_enable = interrupt_enable;
		next_interrupt_routing = interrupt_routing;
		next_pin_cfg = pin_cfg;
		// a write lands in its data phase, when hwdata is on the bus
		if (write_pending)
		begin
			case (write_index)
				airq_pkg::PIN_CONTROL_INDEX:
				begin
					next_pin_cfg.irq_active_level = i_hwdata[airq_pkg::ACTIVE_LEVEL_BIT];
					next_pin_cfg.irq_drive_type = i_hwdata[airq_pkg::DRIVE_TYPE_BIT];
				end
				airq_pkg::ENABLE_INDEX:
				begin
					next_interrupt_enable = source_bits(i_hwdata[7:0]);
				end
				airq_pkg::ROUTING_INDEX:
				begin
					next_interrupt_routing = source_bits(i_hwdata[7:0]);
				end
				default:
				begin
					// unmapped or read-only: write is dropped, still OKAY
					next_pin_cfg = pin_cfg;
				end
			endcase
		end
		// only a new address phase starts another data phase
		next_write_pending = transfer_valid & i_hwrite;
		next_write_index = transfer_valid ? addr_index : write_index;
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data: pin control, enable and routing taken from next values so a write just landing is seen

	always_comb
	begin
		next_hrdata = o_hrdata;
		if (transfer_valid && !i_hwrite)
		begin
			next_hrdata = '0;
			case (addr_index)
				airq_pkg::PIN_CONTROL_INDEX:
				begin
					next_hrdata[airq_pkg::ACTIVE_LEVEL_BIT] = next_pin_cfg.irq_active_level;
					next_hrdata[airq_pkg::DRIVE_TYPE_BIT] = next_pin_cfg.irq_drive_type;
				end
				airq_pkg::ENABLE_INDEX:
				begin
					next_hrdata[7:0] = next_interrupt_enable;
				end
				airq_pkg::ROUTING_INDEX:
				begin
					next_hrdata[7:0] = next_interrupt_routing;
				end
				airq_pkg::STATUS_INDEX:
				begin
					// live view only; the latched source status lives elsewhere
					next_hrdata[7:0] = gated_events;
					next_hrdata[airq_pkg::STATUS_PRIMARY_BIT] = primary_request;
					next_hrdata[airq_pkg::STATUS_SECONDARY_BIT] = secondary_request;
					next_hrdata[airq_pkg::STATUS_PRIMARY_PIN_BIT] = primary_pin_level;
					next_hrdata[airq_pkg::STATUS_SECONDARY_PIN_BIT] = secondary_pin_level;
				end
				default:
				begin
					// unmapped reads return zero
					next_hrdata = '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	// configuration registers
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			interrupt_enable <= airq_pkg::ENABLE_RESET;
			interrupt_routing <= airq_pkg::ROUTING_RESET;
			pin_cfg <= airq_pkg::airq_pin_cfg_t'(airq_pkg::PIN_CONTROL_RESET[1:0]);
		end
		else
		begin
			interrupt_enable <= next_interrupt_enable;
			interrupt_routing <= next_interrupt_routing;
			pin_cfg <= next_pin_cfg;
		end
	end

	// bus state and answer; zero wait states, so hreadyout stays high
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			write_pending <= 1'b0;
			write_index <= '0;
			o_hrdata <= '0;
			o_hreadyout <= 1'b1;
			o_hresp <= airq_pkg::HRESP_OKAY;
		end
		else
		begin
			write_pending <= next_write_pending;
			write_index <= next_write_index;
			o_hrdata <= next_hrdata;
			o_hreadyout <= 1'b1;
			o_hresp <= airq_pkg::HRESP_OKAY;
		end
	end

	// pin levels for the status view; inputs are synchronous to the clock
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			primary_pin_level <= 1'b1;
			secondary_pin_level <= 1'b1;
		end
		else
		begin
			primary_pin_level <= i_irq_line_primary_in;
			secondary_pin_level <= i_irq_line_secondary_in;
		end
	end

	// the size input is accepted but unused: only whole-word transfers occur
	logic unused_size;
	assign unused_size = ^i_hsize;

endmodule : airq_router
`default_nettype wire

// File: hdl/airq_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared types and constants of the interrupt enable and routing block
////////////////////////////////////////////////////////////////////////////////
package airq_pkg;

	// one bit per interrupt source, in register bit order (bit 7 first)
	typedef struct packed
	{
		logic sleep_wake;       // auto sleep/wake event, bit 7
		logic fifo;             // fifo event, bit 6
		logic transient;        // transient detection, bit 5
		logic orientation;      // orientation change, bit 4
		logic pulse;            // pulse detection, bit 3
		logic freefall_motion;  // freefall/motion detection, bit 2
		logic unused;           // bit 1, no source behind it
		logic data_ready;       // new sample ready, bit 0
	} airq_sources_t;

	// pin configuration bits, in pin control register order
	typedef struct packed
	{
		logic irq_active_level; // 0: asserted as low, 1: asserted as high
		logic irq_drive_type;   // 0: push-pull, 1: open-drain
	} airq_pin_cfg_t;

	// output and output enable of one interrupt pin
	typedef struct packed
	{
		logic out;              // level driven while oe is high
		logic oe;               // high while the pin is driven
	} airq_pin_drive_t;

	////////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [5:0] PIN_CONTROL_INDEX = 6'h2C;
	localparam logic [5:0] ENABLE_INDEX = 6'h2D;
	localparam logic [5:0] ROUTING_INDEX = 6'h2E;
	localparam logic [5:0] STATUS_INDEX = 6'h3F;

	// reset values
	localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] ROUTING_RESET = 8'h00;

	// writable source bits; bit 1 has no source and reads as zero
	localparam logic [7:0] SOURCE_MASK = 8'hFD;

	// field positions in the pin control register
	localparam int ACTIVE_LEVEL_BIT = 1;
	localparam int DRIVE_TYPE_BIT = 0;

	// field positions in the status register (bits 7..0 are gated events)
	localparam int STATUS_PRIMARY_BIT = 8;
	localparam int STATUS_SECONDARY_BIT = 9;
	localparam int STATUS_PRIMARY_PIN_BIT = 10;
	localparam int STATUS_SECONDARY_PIN_BIT = 11;

	// pin state during reset: push-pull, active low, deasserted
	localparam airq_pin_drive_t PIN_DRIVE_RESET = '{out: 1'b1, oe: 1'b1};

	// ahb-lite codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'b0;

endpackage : airq_pkg

// File: hdl/airq_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// output stage of one interrupt pin: polarity and drive type, registered
////////////////////////////////////////////////////////////////////////////////
module airq_pin_driver
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_assert,
	input wire airq_pkg::airq_pin_cfg_t i_cfg,
	output airq_pkg::airq_pin_drive_t o_drive
);

	// logical level the pin should show
	logic pin_level;
	// next registered drive
	airq_pkg::airq_pin_drive_t next_drive;

	// polarity and drive type decode
	always_comb
	begin
		pin_level = i_assert ? i_cfg.irq_active_level : ~i_cfg.irq_active_level;
		if (i_cfg.irq_drive_type)
		begin
			// open-drain only pulls low, the line's pull-up gives the high level
			next_drive.out = 1'b0;
			next_drive.oe = ~pin_level;
		end
		else
		begin
			// push-pull drives both levels
			next_drive.out = pin_level;
			next_drive.oe = 1'b1;
		end
	end

	// register the pin so it never glitches on decode hazards
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_drive <= airq_pkg::PIN_DRIVE_RESET;
		end
		else
		begin
			o_drive <= next_drive;
		end
	end

endmodule : airq_pin_driver
`default_nettype wire

// File: testbench/airq_router_asserts.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// port checker; keeps a shadow of the writable registers
module airq_router_asserts
#(
	parameter int ADDR_WIDTH = 8
)
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_hsel,
	input wire logic [ADDR_WIDTH-1:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire airq_pkg::airq_sources_t i_event_flags,
	input wire logic i_irq_line_primary_in,
	input wire logic o_irq_line_primary_out,
	input wire logic o_irq_line_primary_oe,
	input wire logic i_irq_line_secondary_in,
	input wire logic o_irq_line_secondary_out,
	input wire logic o_irq_line_secondary_oe
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	logic take; // address phase accepted
	logic wr_pend; // write data phase open
	logic [5:0] idx; // index of the open write
	logic [7:0] en; // shadow enable
	logic [7:0] rt; // shadow routing
	logic [7:0] pc; // shadow pin control
	logic [7:0] g; // enabled event flags
	logic lp; // expected primary level
	logic ls; // expected secondary level
	assign take = i_hsel & i_hready & i_htrans[1];
	assign g = i_event_flags & en;
	assign lp = ~((|(g & rt)) ^ pc[1]);
	assign ls = ~((|(g & ~rt)) ^ pc[1]);
	// shadow follows writes at the edge ending the data phase
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_pend <= 1'b0;
			idx <= 6'h00;
			en <= 8'h00;
			rt <= 8'h00;
			pc <= 8'h00;
		end
		else
		begin
			wr_pend <= take & i_hwrite;
			idx <= i_haddr[7:2];
			if (wr_pend && idx == airq_pkg::ENABLE_INDEX)
				en <= i_hwdata[7:0] & airq_pkg::SOURCE_MASK;
			if (wr_pend && idx == airq_pkg::ROUTING_INDEX)
				rt <= i_hwdata[7:0] & airq_pkg::SOURCE_MASK;
			if (wr_pend && idx == airq_pkg::PIN_CONTROL_INDEX)
				pc <= {6'h00, i_hwdata[1:0]};
		end
	end
	sequence rd_s(logic [5:0] x);
		take && !i_hwrite && i_haddr[7:2] == x;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	// pin levels, read back and bus answer
	AST_PRI_OUT: assert property (1'b1 |=> o_irq_line_primary_out == ($past(pc[0]) ? 1'b0 : $past(lp)))
		else $error("primary pin level wrong");
	AST_PRI_OE: assert property (!pc[0] |=> o_irq_line_primary_oe)
		else $error("primary pin not driven");
	AST_SEC_OUT: assert property (1'b1 |=> o_irq_line_secondary_out == ($past(pc[0]) ? 1'b0 : $past(ls)))
		else $error("secondary pin level wrong");
	AST_SEC_OE: assert property (pc[0] |=> o_irq_line_secondary_oe == ~$past(ls))
		else $error("secondary pin enable wrong");
	AST_DISABLED: assert property (g == 8'h00 && !pc[0] |=>
		o_irq_line_primary_out == ~$past(pc[1]) && o_irq_line_secondary_out == ~$past(pc[1]))
		else $error("disabled source reached a pin");
	AST_RD_EN: assert property (rd_s(airq_pkg::ENABLE_INDEX) |=> o_hrdata == {24'h000000, en})
		else $error("enable read wrong");
	AST_RD_RT: assert property (rd_s(airq_pkg::ROUTING_INDEX) |=> o_hrdata == {24'h000000, rt})
		else $error("routing read wrong");
	AST_BUS: assert property (take |-> o_hreadyout && o_hresp == airq_pkg::HRESP_OKAY)
		else $error("bus answer wrong");
	cover property (take && i_hwrite);
	cover property (!pc[0] && |(g & rt));
	cover property (pc[0] && |(g & ~rt));
endmodule : airq_router_asserts
`default_nettype wire

// File: testbench/airq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// host side of the two lines; each line has a pull-up
module airq_host_model
(
	input wire logic i_p_out,
	input wire logic i_p_oe,
	input wire logic i_s_out,
	input wire logic i_s_oe,
	output logic o_p_wire,
	output logic o_s_wire
);
	// a released line floats high, so open-drain pins can share it
	assign o_p_wire = i_p_oe ? i_p_out : 1'b1;
	assign o_s_wire = i_s_oe ? i_s_out : 1'b1;
endmodule : airq_host_model
`default_nettype wire

// File: testbench/test_airq_router.sv
`timescale 1ns/1ps
`default_nettype none
module test_airq_router;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic i_hsel = 1'b0;
	logic [7:0] i_haddr = 8'h00;
	logic [1:0] i_htrans = 2'h0;
	logic i_hwrite = 1'b0;
	logic [31:0] i_hwdata = 32'h0;
	airq_pkg::airq_sources_t i_event_flags = '0;
	logic [31:0] o_hrdata;
	logic o_hreadyout;
	logic o_hresp;
	logic p_out, p_oe, s_out, s_oe, p_wire, s_wire;
	logic smp = 1'b0; // monitor samples at the next edge
	logic kind = 1'b0; // 0 read data, 1 pin state
	logic [31:0] q[$]; // expected results, oldest first
	logic [31:0] rng = 32'h000011FE; // xorshift state
	logic [31:0] r;
	int fail_count = 0;
	int num_checks = 0;
	airq_router #(.ADDR_WIDTH(8)) u_airq_router (.i_clock(i_clock), .i_rstn(i_rstn), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
		.i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
		.i_event_flags(i_event_flags), .i_irq_line_primary_in(p_wire), .o_irq_line_primary_out(p_out),
		.o_irq_line_primary_oe(p_oe), .i_irq_line_secondary_in(s_wire), .o_irq_line_secondary_out(s_out),
		.o_irq_line_secondary_oe(s_oe));
	airq_host_model u_airq_host_model (.i_p_out(p_out), .i_p_oe(p_oe), .i_s_out(s_out), .i_s_oe(s_oe),
		.o_p_wire(p_wire), .o_s_wire(s_wire));
	initial
	begin
		forever #4 i_clock = ~i_clock;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs
	// one ahb-lite single transfer; reads note their expected data
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d, input logic [31:0] exp);
		@(posedge i_clock);
		i_hsel <= 1'b1;
		i_htrans <= airq_pkg::HTRANS_NONSEQ;
		i_haddr <= {idx, 2'b00};
		i_hwrite <= wr;
		do @(posedge i_clock); while (o_hreadyout !== 1'b1);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		if (!wr)
		begin
			q.push_back(exp);
			smp <= 1'b1;
			kind <= 1'b0;
		end
		do @(posedge i_clock); while (o_hreadyout !== 1'b1);
		smp <= 1'b0;
	endtask : bus
	task automatic pins(input logic [31:0] exp);
		@(posedge i_clock);
		q.push_back(exp);
		smp <= 1'b1;
		kind <= 1'b1;
		@(posedge i_clock);
		smp <= 1'b0;
	endtask : pins
	// program one setting, then check pins, read back and status
	task automatic step(input logic [7:0] en, input logic [7:0] rt, input logic [1:0] pc, input logic [7:0] fl);
		logic [7:0] g;
		logic rp, rs, lp, ls;
		g = fl & en & airq_pkg::SOURCE_MASK;
		rp = |(g & rt);
		rs = |(g & ~rt);
		lp = ~(rp ^ pc[1]);
		ls = ~(rs ^ pc[1]);
		i_event_flags <= fl;
		bus(1'b1, airq_pkg::ENABLE_INDEX, (xs() & 32'hFFFFFF00) | {24'h0, en}, 32'h0);
		bus(1'b1, airq_pkg::ROUTING_INDEX, {24'h0, rt}, 32'h0);
		bus(1'b1, airq_pkg::PIN_CONTROL_INDEX, {30'h0, pc}, 32'h0);
		repeat (2) @(posedge i_clock);
		pins(pc[0] ? {28'h0, 1'b0, ~lp, 1'b0, ~ls} : {28'h0, lp, 1'b1, ls, 1'b1});
		bus(1'b0, airq_pkg::ENABLE_INDEX, 32'h0, {24'h0, en & airq_pkg::SOURCE_MASK});
		bus(1'b0, airq_pkg::ROUTING_INDEX, 32'h0, {24'h0, rt & airq_pkg::SOURCE_MASK});
		bus(1'b0, airq_pkg::STATUS_INDEX, 32'h0, {20'h0, ls, lp, rs, rp, g});
	endtask : step
	// compares each result with the oldest note
	always @(posedge i_clock)
	begin
		if (smp === 1'b1 && q.size() > 0)
			check(kind ? {28'h0, p_out, p_oe, s_out, s_oe} : o_hrdata, q.pop_front());
		else if (smp === 1'b1)
			fail_count++;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (20000) @(posedge i_clock);
		fail_count++;
		end_sim();
	end
	initial
	begin
		repeat (4) @(posedge i_clock);
		i_rstn <= 1'b1;
		bus(1'b0, airq_pkg::ROUTING_INDEX, 32'h0, 32'h0);
		bus(1'b0, airq_pkg::ENABLE_INDEX, 32'h0, 32'h0);
		bus(1'b0, airq_pkg::PIN_CONTROL_INDEX, 32'h0, 32'h0);
		bus(1'b1, airq_pkg::STATUS_INDEX, 32'hFFFFFFFF, 32'h0);
		bus(1'b0, 6'h00, 32'h0, 32'h0);
		// to each source alone, then all others enabled
		for (int i = 0; i < 8; i++)
		begin
			step(8'h01 << i, i[0] ? 8'hFF : 8'h00, i[2:1], 8'h01 << i);
			step(~(8'h01 << i), 8'hFF, i[1:0], 8'h01 << i);
		end
		for (int i = 0; i < 40; i++)
		begin
			r = xs();
			step(r[7:0], r[15:8], r[17:16], r[31:24]);
		end
		end_sim();
	end
endmodule : test_airq_router
bind airq_router airq_router_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_airq_router_asserts (.i_clock(i_clock),
	.i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
	.i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_event_flags(i_event_flags),
	.i_irq_line_primary_in(i_irq_line_primary_in), .o_irq_line_primary_out(o_irq_line_primary_out),
	.o_irq_line_primary_oe(o_irq_line_primary_oe), .i_irq_line_secondary_in(i_irq_line_secondary_in),
	.o_irq_line_secondary_out(o_irq_line_secondary_out), .o_irq_line_secondary_oe(o_irq_line_secondary_oe));
`default_nettype wire
